// ==== logic/touch_timing_pkg.sv ====
// constants, register map and types for touch scan timing and power control
package touch_timing_pkg;
  localparam int NUM_KEYS = 24;
  localparam int CLK_HZ = 10_000_000;
  // base millisecond tick, derived from the clock rate
  localparam int TICK_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // fine tick for awake and drift hold, coarse tick for recal delay
  localparam int FINE_TICK_MS = 50;
  localparam int COARSE_TICK_FINE = 5;
  localparam int SYNC_WAIT_MS = 100;
  localparam int DEBUG_BIT_NS = 8_700;
  localparam int DEBUG_BIT_CYCLES = DEBUG_BIT_NS / 100;
  // setup byte addresses
  localparam logic [7:0] ADDR_RECAL_DELAY = 8'hed;
  localparam logic [7:0] ADDR_SLEEP_SYNC = 8'hee;
  localparam logic [7:0] ADDR_AWAKE = 8'hef;
  localparam logic [7:0] ADDR_DRIFT_HOLD = 8'hf0;
  // values after reset
  localparam logic [7:0] RST_RECAL_DELAY = 8'h14;
  localparam logic [7:0] RST_SLEEP_SYNC = 8'h10;
  localparam logic [7:0] RST_AWAKE = 8'h19;
  localparam logic [7:0] RST_DRIFT_HOLD = 8'h00;
  // field positions in the sleep/sync/hysteresis/debug byte
  localparam int SLEEP_LSB = 0;
  localparam int LSYNC_BIT = 3;
  localparam int HYST_LSB = 4;
  localparam int DEBUG_LSB = 6;
  // sleep period look-up, index 0 means sleep off
  localparam logic [9:0] SLEEP_LUT_MS [8] = '{10'h000, 10'h010, 10'h020, 10'h040,
                                               10'h080, 10'h100, 10'h200, 10'h3e8};
  localparam logic [7:0] FRAME_BASE_BYTES = 8'h20;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 8;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SCAN, ST_DEBUG, ST_SYNC, ST_SLEEP
  } scan_state_e;
endpackage : touch_timing_pkg

// ==== logic/byte_stream_if.sv ====
// byte stream carrier between the debug fifo and the serialiser
interface byte_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

// ==== logic/byte_fifo.sv ====
// synchronous fifo with valid/ready on both sides
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  byte_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [AW:0] count_ff;
  wire push = wr_valid && wr_ready;
  wire pop = rd.valid && rd.ready;

  // full and empty come straight from the occupancy count
  assign wr_ready = (count_ff != (AW+1)'(DEPTH));
  assign rd.valid = (count_ff != '0);
  assign rd.data = mem_ff[rptr_ff];

  // storage has no reset, pointers do
  always_ff @(posedge core_clk) begin
    if (push) mem_ff[wptr_ff] <= wr_data;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) wptr_ff <= (wptr_ff == AW'(DEPTH - 1)) ? '0 : wptr_ff + 1'b1;
      if (pop) rptr_ff <= (rptr_ff == AW'(DEPTH - 1)) ? '0 : rptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : byte_fifo

// ==== logic/debug_serialiser.sv ====
// asynchronous-style serial transmitter for debug frame bytes
module debug_serialiser #(
  parameter int BIT_CYCLES = 87
) (
  input wire logic core_clk,
  input wire logic srst,
  byte_stream_if.snk bytes,
  output logic line_o,
  output logic byte_sent_o
);
  logic [9:0] shift_ff;
  logic [3:0] bits_ff;
  logic [15:0] baud_ff;
  wire busy = (bits_ff != 4'h0);
  wire bit_end = busy && (baud_ff == 16'(BIT_CYCLES - 1));

  // take a new byte only while idle, so the fifo really backs up
  assign bytes.ready = !busy;

  // start bit low, eight data bits lsb first, stop bit high
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shift_ff <= 10'h3ff;
      bits_ff <= 4'h0;
      baud_ff <= 16'h0000;
      line_o <= 1'b1;
      byte_sent_o <= 1'b0;
    end else begin
      byte_sent_o <= 1'b0;
      if (!busy && bytes.valid) begin
        shift_ff <= {1'b1, bytes.data, 1'b0};
        bits_ff <= 4'ha;
        baud_ff <= 16'h0000;
      end else if (bit_end) begin
        shift_ff <= {1'b1, shift_ff[9:1]};
        bits_ff <= bits_ff - 1'b1;
        baud_ff <= 16'h0000;
        byte_sent_o <= (bits_ff == 4'h1);
      end else if (busy) begin
        baud_ff <= baud_ff + 1'b1;
      end
      line_o <= busy ? shift_ff[0] : 1'b1;
    end
  end
endmodule : debug_serialiser

// ==== logic/touch_scan_timing.sv ====
// scan timing, sleep, line sync, debug frame and drift hold supervision
// Notes on behaviour
// - auto recal after detection exceeds delay
// - zero delay: no auto recal, host recal kept
// - delay counts half seconds, 250 ms accuracy
// - sleep: periodic wake, scan, sleep, lut period
// - no sleep while detecting or calibrating
// - sleep halts timers and drift compensation
// - wake key change drives change low, fast
// - line sync once per full matrix scan
// - after scan wait 100 ms for falling edge
// - missing sync edge: scan after 100 ms
// - hysteresis code picks 6.25 to 50 percent
// - hysteresis applies only to detecting keys
// - debug code picks 32/64/128 byte frames
// - next scan waits for frame fully sent
// - awake timeout 100 ms steps from release
// - sleep off ignores awake timeout
// - detection holds drift for set time
// - zero hold time: drift independent per key
// - any key activity restarts awake period
module touch_scan_timing
  import touch_timing_pkg::*;
#(
  parameter int MS_TICK_CYCLES = touch_timing_pkg::MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic setup_wr_en,
  input wire logic [7:0] setup_addr,
  input wire logic [7:0] setup_wdata,
  output logic [7:0] setup_rdata,
  input wire logic [touch_timing_pkg::NUM_KEYS-1:0] key_detect,
  input wire logic [touch_timing_pkg::NUM_KEYS-1:0] key_calibrating,
  input wire logic [touch_timing_pkg::NUM_KEYS-1:0] key_change,
  input wire logic [touch_timing_pkg::NUM_KEYS-1:0] key_wake_en,
  input wire logic [touch_timing_pkg::NUM_KEYS-1:0] host_recal,
  output logic [touch_timing_pkg::NUM_KEYS-1:0] key_recal,
  output logic scan_start,
  input wire logic scan_done,
  input wire logic line_sync_input,
  input wire logic [11:0] detect_span,
  output logic [11:0] dropout_margin,
  output logic [touch_timing_pkg::NUM_KEYS-1:0] hyst_apply,
  input wire logic dbg_in_valid,
  output logic dbg_in_ready,
  input wire logic [7:0] dbg_in_data,
  output logic debug_pin_o,
  output logic debug_pin_oe,
  input wire logic change_ack,
  output logic change_n_o,
  output logic change_n_oe,
  output logic fast_mode,
  output logic asleep,
  output logic drift_enable
);
  import touch_timing_pkg::*;

  // frame length from the debug code, zero when off
  function automatic logic [7:0] frame_bytes(input logic [1:0] code);
    unique case (code)
      2'd0: frame_bytes = 8'h00;
      2'd1: frame_bytes = FRAME_BASE_BYTES;
      2'd2: frame_bytes = FRAME_BASE_BYTES << 1;
      2'd3: frame_bytes = FRAME_BASE_BYTES << 2;
    endcase
  endfunction : frame_bytes

  // setup bytes as written by the host
  logic [7:0] recal_delay_setting_ff;
  logic [7:0] sleep_sync_hysteresis_debug_setting_ff;
  logic [7:0] awake_timeout_setting_ff;
  logic [7:0] drift_hold_setting_ff;
  // settings in force for the current scan cycle
  logic [7:0] negative_recal_delay_ff;
  logic [2:0] sleep_idx_ff;
  logic line_sync_enable_ff;
  logic [1:0] dropout_hysteresis_ff;
  logic [1:0] debug_code_ff;
  logic [7:0] awake_ff;
  logic [7:0] drift_hold_time_ff;

  scan_state_e state_ff;
  scan_state_e nxt_state;
  logic [15:0] ms_div_ff;
  logic [5:0] fine_div_ff;
  logic [2:0] coarse_div_ff;
  logic [9:0] wait_ms_ff;
  logic [7:0] sent_ff;
  logic [8:0] awake_cnt_ff;
  logic [8:0] hold_cnt_ff;
  logic [NUM_KEYS-1:0] detect_q_ff;
  logic sync_q_ff;
  logic change_flag_ff;
  logic byte_sent;

  // shared decodes
  wire ms_tick = (ms_div_ff == 16'(MS_TICK_CYCLES - 1));
  wire in_sleep = (state_ff == ST_SLEEP);
  wire run_tick = ms_tick && !in_sleep;
  wire fine_tick = run_tick && (fine_div_ff == 6'(FINE_TICK_MS - 1));
  wire coarse_tick = fine_tick && (coarse_div_ff == 3'(COARSE_TICK_FINE - 1));
  wire any_detect = |key_detect;
  wire any_cal = |key_calibrating;
  wire any_activity = (|key_change) || any_detect;
  wire wake_event = |(key_change & key_wake_en);
  wire new_detect = |(key_detect & ~detect_q_ff);
  wire sync_fall = sync_q_ff && !line_sync_input;
  wire sync_timeout = (wait_ms_ff == 10'(SYNC_WAIT_MS));
  wire [9:0] sleep_period = SLEEP_LUT_MS[sleep_idx_ff];
  wire sleep_done = (wait_ms_ff >= sleep_period);
  wire sleep_on = (sleep_idx_ff != 3'd0);
  wire awake_idle = (awake_cnt_ff == 9'h000);
  wire sleep_ok = sleep_on && awake_idle && !any_detect && !any_cal && !wake_event;
  wire frame_done = (sent_ff == frame_bytes(debug_code_ff));
  wire [7:0] read_mux = (setup_addr == ADDR_RECAL_DELAY) ? recal_delay_setting_ff :
                        (setup_addr == ADDR_SLEEP_SYNC) ? sleep_sync_hysteresis_debug_setting_ff :
                        (setup_addr == ADDR_AWAKE) ? awake_timeout_setting_ff :
                        (setup_addr == ADDR_DRIFT_HOLD) ? drift_hold_setting_ff : 8'h00;

  // host setup writes land in the holding bytes only
  always_ff @(posedge core_clk) begin
    if (srst) begin
      recal_delay_setting_ff <= RST_RECAL_DELAY;
      sleep_sync_hysteresis_debug_setting_ff <= RST_SLEEP_SYNC;
      awake_timeout_setting_ff <= RST_AWAKE;
      drift_hold_setting_ff <= RST_DRIFT_HOLD;
      setup_rdata <= 8'h00;
    end else begin
      if (setup_wr_en && setup_addr == ADDR_RECAL_DELAY) recal_delay_setting_ff <= setup_wdata;
      if (setup_wr_en && setup_addr == ADDR_SLEEP_SYNC) begin
        sleep_sync_hysteresis_debug_setting_ff <= setup_wdata;
      end
      if (setup_wr_en && setup_addr == ADDR_AWAKE) awake_timeout_setting_ff <= setup_wdata;
      if (setup_wr_en && setup_addr == ADDR_DRIFT_HOLD) drift_hold_setting_ff <= setup_wdata;
      setup_rdata <= read_mux;
    end
  end

  // settings are taken over only when a new scan cycle starts
  always_ff @(posedge core_clk) begin
    if (srst) begin
      negative_recal_delay_ff <= RST_RECAL_DELAY;
      sleep_idx_ff <= RST_SLEEP_SYNC[SLEEP_LSB +: 3];
      line_sync_enable_ff <= RST_SLEEP_SYNC[LSYNC_BIT];
      dropout_hysteresis_ff <= RST_SLEEP_SYNC[HYST_LSB +: 2];
      debug_code_ff <= RST_SLEEP_SYNC[DEBUG_LSB +: 2];
      awake_ff <= RST_AWAKE;
      drift_hold_time_ff <= RST_DRIFT_HOLD;
    end else if (state_ff == ST_IDLE) begin
      negative_recal_delay_ff <= recal_delay_setting_ff;
      sleep_idx_ff <= sleep_sync_hysteresis_debug_setting_ff[SLEEP_LSB +: 3];
      line_sync_enable_ff <= sleep_sync_hysteresis_debug_setting_ff[LSYNC_BIT];
      dropout_hysteresis_ff <= sleep_sync_hysteresis_debug_setting_ff[HYST_LSB +: 2];
      debug_code_ff <= sleep_sync_hysteresis_debug_setting_ff[DEBUG_LSB +: 2];
      awake_ff <= awake_timeout_setting_ff;
      drift_hold_time_ff <= drift_hold_setting_ff;
    end
  end

  // timebase: ms tick runs always, fine and coarse ticks stop in sleep
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ms_div_ff <= 16'h0000;
      fine_div_ff <= 6'h00;
      coarse_div_ff <= 3'h0;
    end else begin
      ms_div_ff <= ms_tick ? 16'h0000 : ms_div_ff + 1'b1;
      if (run_tick) fine_div_ff <= (fine_div_ff == 6'(FINE_TICK_MS - 1)) ? 6'h00 : fine_div_ff + 1'b1;
      if (fine_tick) begin
        coarse_div_ff <= (coarse_div_ff == 3'(COARSE_TICK_FINE - 1)) ? 3'h0 : coarse_div_ff + 1'b1;
      end
    end
  end

  // per-key negative recal timers, counted in 250 ms steps
  for (genvar k = 0; k < NUM_KEYS; k++) begin : g_recal
    logic [8:0] hold_ff;
    logic recal_ff;
    wire expire = (negative_recal_delay_ff != 8'h00) &&
                  (hold_ff >= {negative_recal_delay_ff, 1'b0});
    always_ff @(posedge core_clk) begin
      if (srst) begin
        hold_ff <= 9'h000;
        recal_ff <= 1'b0;
      end else begin
        recal_ff <= (key_detect[k] && expire) || host_recal[k];
        if (!key_detect[k] || expire) hold_ff <= 9'h000;
        else if (coarse_tick) hold_ff <= hold_ff + 1'b1;
      end
    end
    assign key_recal[k] = recal_ff;
  end

  // awake period reloads on any key activity, runs down after release
  always_ff @(posedge core_clk) begin
    if (srst) begin
      awake_cnt_ff <= {RST_AWAKE, 1'b0};
    end else if (any_activity) begin
      awake_cnt_ff <= {awake_ff, 1'b0};
    end else if (fine_tick && !awake_idle) begin
      awake_cnt_ff <= awake_cnt_ff - 1'b1;
    end
  end

  // drift hold after any detection; zero setting means no hold
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hold_cnt_ff <= 9'h000;
      detect_q_ff <= '0;
    end else begin
      detect_q_ff <= key_detect;
      if (drift_hold_time_ff == 8'h00) hold_cnt_ff <= 9'h000;
      else if (new_detect || any_detect) hold_cnt_ff <= {drift_hold_time_ff, 1'b0};
      else if (fine_tick && hold_cnt_ff != 9'h000) hold_cnt_ff <= hold_cnt_ff - 1'b1;
    end
  end

  // change flag: a new wake event beats a same-cycle acknowledge
  always_ff @(posedge core_clk) begin
    if (srst) change_flag_ff <= 1'b0;
    else if (wake_event) change_flag_ff <= 1'b1;
    else if (change_ack) change_flag_ff <= 1'b0;
  end

  // scan cycle sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: nxt_state = ST_SCAN;
      ST_SCAN: begin
        if (scan_done) begin
          if (debug_code_ff != 2'd0) nxt_state = ST_DEBUG;
          else if (sleep_ok) nxt_state = ST_SLEEP;
          else if (line_sync_enable_ff) nxt_state = ST_SYNC;
          else nxt_state = ST_IDLE;
        end
      end
      ST_DEBUG: begin
        if (frame_done) begin
          if (sleep_ok) nxt_state = ST_SLEEP;
          else if (line_sync_enable_ff) nxt_state = ST_SYNC;
          else nxt_state = ST_IDLE;
        end
      end
      ST_SLEEP: begin
        if (sleep_done || wake_event) begin
          nxt_state = line_sync_enable_ff ? ST_SYNC : ST_IDLE;
        end
      end
      ST_SYNC: begin
        if (sync_fall || sync_timeout) nxt_state = ST_IDLE;
      end
    endcase
  end

  // state, wait timer, frame byte count and scan start strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff <= ST_IDLE;
      wait_ms_ff <= 10'h000;
      sent_ff <= 8'h00;
      scan_start <= 1'b0;
      sync_q_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      sync_q_ff <= line_sync_input;
      scan_start <= (state_ff == ST_IDLE);
      if (nxt_state != state_ff) wait_ms_ff <= 10'h000;
      else if (ms_tick && wait_ms_ff != 10'h3ff) wait_ms_ff <= wait_ms_ff + 1'b1;
      if (state_ff == ST_IDLE) sent_ff <= 8'h00;
      else if (byte_sent && !frame_done) sent_ff <= sent_ff + 1'b1;
    end
  end

  // drop-out margin: span shifted right by 4, 3, 2 or 1
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dropout_margin <= 12'h000;
      hyst_apply <= '0;
    end else begin
      dropout_margin <= detect_span >> (3'd4 - {1'b0, dropout_hysteresis_ff});
      hyst_apply <= key_detect;
    end
  end

  // debug bytes pass through an 8-deep fifo to the serialiser
  byte_stream_if dbg_bytes ();

  byte_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .wr_valid(dbg_in_valid),
    .wr_ready(dbg_in_ready),
    .wr_data(dbg_in_data),
    .rd(dbg_bytes.src)
  );

  debug_serialiser #(
    .BIT_CYCLES(DEBUG_BIT_CYCLES)
  ) u_ser (
    .core_clk(core_clk),
    .srst(srst),
    .bytes(dbg_bytes.snk),
    .line_o(debug_pin_o),
    .byte_sent_o(byte_sent)
  );

  // outputs; the change pin is open drain and only ever pulls low
  assign debug_pin_oe = (debug_code_ff != 2'd0); // shared pin owned only when enabled
  assign change_n_o = 1'b0;
  assign change_n_oe = change_flag_ff;
  assign fast_mode = !awake_idle;
  assign asleep = in_sleep;
  assign drift_enable = !in_sleep && (hold_cnt_ff == 9'h000);
endmodule : touch_scan_timing

// ==== dv/touch_scan_timing_asserts.sv ====
// concurrent checks on the scan timing and power control ports
module touch_scan_timing_asserts
  import touch_timing_pkg::*;
#(
  parameter int MS_TICK_CYCLES = 10
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic setup_wr_en,
  input wire logic [7:0] setup_addr,
  input wire logic [7:0] setup_wdata,
  input wire logic [touch_timing_pkg::NUM_KEYS-1:0] key_detect,
  input wire logic [touch_timing_pkg::NUM_KEYS-1:0] key_calibrating,
  input wire logic [touch_timing_pkg::NUM_KEYS-1:0] key_change,
  input wire logic [touch_timing_pkg::NUM_KEYS-1:0] key_wake_en,
  input wire logic [touch_timing_pkg::NUM_KEYS-1:0] host_recal,
  input wire logic [touch_timing_pkg::NUM_KEYS-1:0] key_recal,
  input wire logic scan_start,
  input wire logic [touch_timing_pkg::NUM_KEYS-1:0] hyst_apply,
  input wire logic change_ack,
  input wire logic change_n_oe,
  input wire logic fast_mode,
  input wire logic asleep,
  input wire logic drift_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // host writes shadowed for the checks
  wire wr_rcl = setup_wr_en && setup_addr == ADDR_RECAL_DELAY;
  wire wr_ss = setup_wr_en && setup_addr == ADDR_SLEEP_SYNC;
  wire wr_hld = setup_wr_en && setup_addr == ADDR_DRIFT_HOLD;
  wire wake_evt = |(key_change & key_wake_en);
  logic [7:0] rcl_ff;
  logic [7:0] hld_ff;
  logic [2:0] sleep_ff;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rcl_ff <= RST_RECAL_DELAY;
      hld_ff <= RST_DRIFT_HOLD;
      sleep_ff <= RST_SLEEP_SYNC[2:0];
    end else begin
      if (wr_rcl) rcl_ff <= setup_wdata;
      if (wr_hld) hld_ff <= setup_wdata;
      if (wr_ss) sleep_ff <= setup_wdata[2:0];
    end
  end
  sequence s_wake_evt;
    wake_evt;
  endsequence
  sequence s_flag_and_fast;
    ##[1:2] (change_n_oe && fast_mode);
  endsequence
  a_wake_change: assert property (s_wake_evt |-> s_flag_and_fast)
    else $error("no change flag");
  a_ack_clears: assert property (change_ack && !wake_evt |=> !change_n_oe)
    else $error("flag kept after ack");
  a_host_recal: assert property (|host_recal |=> (key_recal & $past(host_recal)) == $past(host_recal))
    else $error("host recal lost");
  a_recal_off: assert property (rcl_ff == 8'h00 && !(|host_recal) |=> key_recal == '0)
    else $error("recal with zero delay");
  a_sleep_guard: assert property ($rose(asleep) |-> $past(key_detect) == '0 && $past(key_calibrating) == '0)
    else $error("sleep while busy");
  a_sleep_halt: assert property (asleep && $past(asleep) |-> !drift_enable)
    else $error("drift in sleep");
  a_sleep_off: assert property (sleep_ff == 3'h0 && !asleep |=> !asleep)
    else $error("sleep while off");
  a_hyst_copy: assert property (1'b1 |=> hyst_apply == $past(key_detect))
    else $error("hysteresis on idle key");
  a_scan_pulse: assert property (scan_start |=> !scan_start)
    else $error("long scan start");
  a_drift_hold: assert property (hld_ff != 8'h00 && |key_detect |-> ##[1:2] !drift_enable)
    else $error("drift not held");
endmodule : touch_scan_timing_asserts

bind touch_scan_timing touch_scan_timing_asserts #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) i_asserts (
  .core_clk, .srst, .setup_wr_en, .setup_addr, .setup_wdata, .key_detect, .key_calibrating,
  .key_change, .key_wake_en, .host_recal, .key_recal, .scan_start, .hyst_apply, .change_ack,
  .change_n_oe, .fast_mode, .asleep, .drift_enable
);

// ==== dv/scan_engine_model.sv ====
// far side: scan engine and debug byte source
module scan_engine_model
  import touch_timing_pkg::*;
#(
  parameter int DONE_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic scan_start,
  output logic scan_done,
  input wire logic stream_en,
  output logic dbg_valid,
  input wire logic dbg_ready,
  output logic [7:0] dbg_data
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_ff;
  logic [7:0] next_byte_ff;
  // a matrix scan takes a fixed time; done is a one-cycle answer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_ff <= 0;
    end else if (scan_start) begin
      cnt_ff <= DONE_CYCLES;
    end else if (cnt_ff != 0) begin
      cnt_ff <= cnt_ff - 1;
    end
  end
  assign scan_done = (cnt_ff == 1);
  // byte held until ready; idle data toggles so stale bytes show
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dbg_valid <= 1'b0;
      dbg_data <= 8'hff;
      next_byte_ff <= 8'h00;
    end else if (!dbg_valid || dbg_ready) begin
      dbg_valid <= stream_en;
      dbg_data <= stream_en ? next_byte_ff : ~dbg_data;
      next_byte_ff <= next_byte_ff + {7'h0, stream_en};
    end
  end
endmodule : scan_engine_model

// ==== dv/testbench.sv ====
// self-checking bench for scan timing, sleep, sync, debug and drift hold
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import touch_timing_pkg::*;
  logic core_clk, srst, setup_wr_en, scan_start, scan_done, line_sync_input;
  logic [7:0] setup_addr, setup_wdata, setup_rdata, dbg_in_data;
  logic [NUM_KEYS-1:0] key_detect, key_calibrating, key_change, key_wake_en;
  logic [NUM_KEYS-1:0] host_recal, key_recal, hyst_apply;
  logic [11:0] detect_span, dropout_margin;
  logic dbg_in_valid, dbg_in_ready, debug_pin_o, debug_pin_oe, change_ack, change_n_o;
  logic change_n_oe, fast_mode, asleep, drift_enable, stream_en;
  logic recal_seen, asleep_seen, full_seen;
  int error_cnt = 0;
  int compares = 0;
  int n;
  touch_scan_timing #(.MS_TICK_CYCLES(10)) i_dut (
    .core_clk, .srst, .setup_wr_en, .setup_addr, .setup_wdata, .setup_rdata, .key_detect,
    .key_calibrating, .key_change, .key_wake_en, .host_recal, .key_recal, .scan_start,
    .scan_done, .line_sync_input, .detect_span, .dropout_margin, .hyst_apply, .dbg_in_valid,
    .dbg_in_ready, .dbg_in_data, .debug_pin_o, .debug_pin_oe, .change_ack, .change_n_o,
    .change_n_oe, .fast_mode, .asleep, .drift_enable
  );
  scan_engine_model i_engine (
    .core_clk(core_clk), .srst(srst), .scan_start(scan_start), .scan_done(scan_done),
    .stream_en(stream_en), .dbg_valid(dbg_in_valid), .dbg_ready(dbg_in_ready),
    .dbg_data(dbg_in_data)
  );
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // sticky flags sampled mid-cycle, away from the launching edge
  always @(negedge core_clk) begin
    if (|key_recal) recal_seen = 1'b1;
    if (asleep) asleep_seen = 1'b1;
    if (!dbg_in_ready) full_seen = 1'b1;
  end
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #10;
  endtask : step
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {15'h0, exp}, {15'h0, got});
  endtask : chk1
  // strobe is lowered and an edge passes, so back-to-back writes never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    setup_wr_en = 1'b1;
    setup_addr = a;
    setup_wdata = d;
    step(1);
    setup_wr_en = 1'b0;
    step(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    setup_addr = a;
    step(1);
    chk("setup_rdata", {8'h00, exp}, {8'h00, setup_rdata});
  endtask : rd
  // cycles to the next scan start, capped so a stall cannot hang the run
  task automatic next_start(input int cap);
    step(1);
    n = 1;
    while (scan_start !== 1'b1 && n < cap) begin
      step(1);
      n++;
    end
  endtask : next_start
  task automatic scans(input int k);
    repeat (k) next_start(2000);
  endtask : scans
  task automatic wait_asleep(input int cap);
    n = 0;
    while (asleep !== 1'b1 && n < cap) begin
      step(1);
      n++;
    end
  endtask : wait_asleep
  // cuts off a hang; the tests take about 56k cycles
  initial begin
    #(100 * 90_000);
    error_cnt++;
    $display("watchdog expired");
    tally_and_finish();
  end
  initial begin
    srst = 1'b1;
    setup_wr_en = 1'b0;
    setup_addr = 8'h00;
    setup_wdata = 8'h00;
    {key_detect, key_calibrating, key_change, host_recal} = '0;
    key_wake_en = '1;
    line_sync_input = 1'b1;
    detect_span = 12'hab0;
    change_ack = 1'b0;
    stream_en = 1'b0;
    {recal_seen, asleep_seen, full_seen} = 3'b000;
    step(5);
    srst = 1'b0;
    rd(ADDR_RECAL_DELAY, 8'h14);
    rd(ADDR_SLEEP_SYNC, 8'h10);
    rd(ADDR_AWAKE, 8'h19);
    rd(ADDR_DRIFT_HOLD, 8'h00);
    chk1("debug line idle", 1'b1, debug_pin_o);
    chk1("change pin level", 1'b0, change_n_o);
    wr(8'h00, 8'ha5);
    rd(8'h00, 8'h00);
    wr(ADDR_DRIFT_HOLD, 8'h5a);
    rd(ADDR_DRIFT_HOLD, 8'h5a);
    wr(ADDR_DRIFT_HOLD, 8'h00);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_SLEEP_SYNC, 8'(c << 4));
      scans(2);
      chk("dropout_margin", {4'h0, 12'hab0 >> (4 - c)}, {4'h0, dropout_margin});
    end
    $display("test hysteresis done");
    wr(ADDR_RECAL_DELAY, 8'h00);
    recal_seen = 1'b0;
    key_detect[3] = 1'b1;
    step(3000);
    chk1("auto recal off", 1'b0, recal_seen);
    host_recal[5] = 1'b1;
    step(1);
    host_recal[5] = 1'b0;
    chk1("host recal", 1'b1, key_recal[5]);
    key_detect[3] = 1'b0;
    wr(ADDR_RECAL_DELAY, 8'h01);
    scans(2);
    key_detect[3] = 1'b1;
    n = 0;
    while (key_recal[3] !== 1'b1 && n < 8000) begin
      step(1);
      n++;
    end
    chk1("recal after half second", 1'b1, n >= 2400 && n <= 5100);
    key_detect[3] = 1'b0;
    $display("test recal done");
    wr(ADDR_DRIFT_HOLD, 8'h01);
    scans(2);
    key_detect[0] = 1'b1;
    step(5);
    key_detect[0] = 1'b0;
    chk1("drift held", 1'b0, drift_enable);
    n = 0;
    while (drift_enable !== 1'b1 && n < 3000) begin
      step(1);
      n++;
    end
    chk1("drift hold length", 1'b1, n >= 400 && n <= 1100);
    wr(ADDR_DRIFT_HOLD, 8'h00);
    scans(2);
    key_detect[0] = 1'b1;
    step(20);
    chk1("drift free", 1'b1, drift_enable);
    key_detect[0] = 1'b0;
    $display("test drift hold done");
    wr(ADDR_SLEEP_SYNC, 8'h18);
    scans(2);
    next_start(2000);
    chk1("sync timeout", 1'b1, n >= 990 && n <= 1060);
    step(100);
    line_sync_input = 1'b0;
    next_start(50);
    chk1("sync edge", 1'b1, n <= 10);
    line_sync_input = 1'b1;
    wr(ADDR_SLEEP_SYNC, 8'h10);
    $display("test line sync done");
    stream_en = 1'b1;
    next_start(2000);
    wr(ADDR_SLEEP_SYNC, 8'h50);
    next_start(2000);
    wr(ADDR_SLEEP_SYNC, 8'h10);
    chk1("debug oe", 1'b1, debug_pin_oe);
    next_start(40000);
    chk1("frame hold-off", 1'b1, n >= 26000 && n <= 33000);
    chk1("fifo refused", 1'b1, full_seen);
    stream_en = 1'b0;
    $display("test debug done");
    wr(ADDR_AWAKE, 8'h04);
    key_calibrating[2] = 1'b1;
    asleep_seen = 1'b0;
    wr(ADDR_SLEEP_SYNC, 8'h11);
    step(6000);
    chk1("no sleep calibrating", 1'b0, asleep_seen);
    key_calibrating[2] = 1'b0;
    wait_asleep(6000);
    chk1("asleep", 1'b1, asleep);
    step(2);
    chk1("drift halted", 1'b0, drift_enable);
    next_start(400);
    chk1("periodic wake", 1'b1, n >= 130 && n <= 200);
    wait_asleep(400);
    key_change[1] = 1'b1;
    step(1);
    key_change[1] = 1'b0;
    step(2);
    chk1("change flag", 1'b1, change_n_oe);
    chk1("fast mode", 1'b1, fast_mode);
    change_ack = 1'b1;
    step(1);
    change_ack = 1'b0;
    chk1("change cleared", 1'b0, change_n_oe);
    key_wake_en = '0;
    step(2000);
    key_change[4] = 1'b1;
    step(1);
    key_change[4] = 1'b0;
    asleep_seen = 1'b0;
    step(2500);
    chk1("awake restarted", 1'b0, asleep_seen);
    wait_asleep(5000);
    chk1("awake timeout", 1'b1, n >= 900 && n <= 1700);
    key_wake_en = '1;
    wr(ADDR_SLEEP_SYNC, 8'h10);
    step(400);
    asleep_seen = 1'b0;
    step(3000);
    chk1("sleep disabled", 1'b0, asleep_seen);
    $display("test sleep done");
    tally_and_finish();
  end
endmodule : testbench
